// ==== msc_params.svh ====
// Register offsets, field positions, reset values and limits of the statistics bank
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH
`define MSC_OFF_RX_BIN_512_1023    16'h406C
`define MSC_OFF_RX_BIN_1024_MAX    16'h4070
`define MSC_OFF_RX_GOOD_PACKETS    16'h4074
`define MSC_OFF_RX_BCAST_PACKETS   16'h4078
`define MSC_OFF_RX_MCAST_PACKETS   16'h407C
`define MSC_OFF_TX_GOOD_PACKETS    16'h4080
`define MSC_OFF_RX_OCTETS_LOW      16'h4088
`define MSC_OFF_RX_OCTETS_HIGH     16'h408C
`define MSC_OFF_TX_OCTETS_LOW      16'h4090
`define MSC_OFF_TX_OCTETS_HIGH     16'h4094
`define MSC_OFF_RX_NO_BUFFER       16'h40A0
`define MSC_OFF_RX_UNDERSIZE       16'h40A4
`define MSC_OFF_RX_FRAGMENT        16'h40A8
`define MSC_OFF_RX_OVERSIZE        16'h40AC
`define MSC_OFF_RX_JABBER          16'h40B0
`define MSC_OFF_CONTROL            16'h40B4
`define MSC_OFF_MAX_LONG_LEN       16'h40B8
`define MSC_CTL_RX_EN_BIT          0
`define MSC_CTL_TX_EN_BIT          1
`define MSC_CTL_LONG_EN_BIT        2
`define MSC_CTL_EXT_VLAN_BIT       3
`define MSC_CTL_BCAST_EN_BIT       4
`define MSC_CNT_RESET              32'h0000_0000
`define MSC_CTL_RESET              32'h0000_0000
`define MSC_MAX_LONG_RESET         16'h2600
`define MSC_LEN_MIN                16'h0040
`define MSC_LEN_RUNT               16'h0019
`define MSC_LEN_BIN_LO             16'h0200
`define MSC_LEN_BIN_HI             16'h03FF
`define MSC_LEN_BIN_TOP            16'h0400
`define MSC_LEN_STD_MAX            16'h05F2
`define MSC_LEN_VLAN_MAX           16'h05F6
`define MSC_RESP_OKAY              2'b00
`define MSC_RESP_SLVERR            2'b10
`endif

// ==== msc_pkg.sv ====
// Types shared by the statistics bank
package msc_pkg;
   typedef struct packed {
      logic        valid;
      logic [15:0] length;
      logic        crc_ok;
      logic        addr_pass;
      logic        bcast;
      logic        mcast;
      logic        flow_ctl;
      logic        missed;
      logic        link_cut;
      logic        desc_empty;
      logic [2:0]  dropped_copies;
   } msc_rx_status_t;
   typedef struct packed {
      logic        valid;
      logic [15:0] length;
      logic        ok;
      logic        flow_ctl;
   } msc_tx_status_t;
   typedef enum logic [3:0] {
      MSC_C_BIN512, MSC_C_BIN1024, MSC_C_RXGOOD, MSC_C_BCAST, MSC_C_MCAST, MSC_C_TXGOOD,
      MSC_C_NOBUF, MSC_C_UNDER, MSC_C_FRAG, MSC_C_OVER, MSC_C_JAB, MSC_C_NUM
   } msc_cnt_t;
   typedef enum {MSC_RD_IDLE, MSC_RD_RESP} msc_rd_state_t;
   typedef enum {MSC_WR_IDLE, MSC_WR_RESP} msc_wr_state_t;
endpackage

// ==== msc_stats.sv ====
// Clear-on-read receive and transmit statistics bank with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "msc_params.svh"
module msc_stats #(
   parameter int ADDR_W = 16
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire msc_pkg::msc_rx_status_t rx_status,
   input  wire msc_pkg::msc_tx_status_t tx_status,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);
   localparam int NC = int'(msc_pkg::MSC_C_NUM);

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);

   if (ADDR_W < 16)
   begin
      $error("ADDR_W must be at least 16");
   end

   // Registers
   logic [31:0]   cnt_r [NC];
   logic [31:0]   cnt_nxt [NC];
   logic [63:0]   rxo_r, rxo_nxt, txo_r, txo_nxt;
   logic [31:0]   rxo_hi_snap_r, rxo_hi_snap_nxt, txo_hi_snap_r, txo_hi_snap_nxt;
   logic [31:0]   ctl_r, ctl_nxt;
   logic [15:0]   max_long_r, max_long_nxt;
   msc_pkg::msc_rd_state_t rd_st_r, rd_st_nxt;
   msc_pkg::msc_wr_state_t wr_st_r, wr_st_nxt;
   logic          aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [31:0]   w_data_r, w_data_nxt;
   logic [3:0]    w_strb_r, w_strb_nxt;
   logic [31:0]   rdata_r, rdata_nxt;
   logic [1:0]    rresp_r, rresp_nxt, bresp_r, bresp_nxt;

   // Frame classification
   logic          rx_en, tx_en, rx_ok, good_crc, legal, oversize, undersize;
   logic [15:0]   max_len;
   logic [NC-1:0] inc;
   logic [2:0]    nobuf_add;
   logic [63:0]   rx_add, tx_add;

   always_comb
   begin
      rx_en     = ctl_r[`MSC_CTL_RX_EN_BIT];
      tx_en     = ctl_r[`MSC_CTL_TX_EN_BIT];
      max_len   = ctl_r[`MSC_CTL_LONG_EN_BIT] ? max_long_r :
                  (ctl_r[`MSC_CTL_EXT_VLAN_BIT] ? `MSC_LEN_VLAN_MAX : `MSC_LEN_STD_MAX);
      oversize  = rx_status.length > max_len;
      undersize = rx_status.length < `MSC_LEN_MIN;
      legal     = !oversize && !undersize;
      good_crc  = rx_status.crc_ok || rx_status.link_cut;
      rx_ok     = rx_status.valid && rx_en && rx_status.addr_pass && !rx_status.missed
                  && !rx_status.flow_ctl && good_crc && legal;
      inc       = '0;
      inc[msc_pkg::MSC_C_BIN512]  = rx_ok && rx_status.length >= `MSC_LEN_BIN_LO
                                    && rx_status.length <= `MSC_LEN_BIN_HI;
      inc[msc_pkg::MSC_C_BIN1024] = rx_ok && rx_status.length >= `MSC_LEN_BIN_TOP;
      inc[msc_pkg::MSC_C_RXGOOD]  = rx_ok;
      inc[msc_pkg::MSC_C_BCAST]   = rx_ok && rx_status.bcast && ctl_r[`MSC_CTL_BCAST_EN_BIT];
      inc[msc_pkg::MSC_C_MCAST]   = rx_ok && rx_status.mcast;
      inc[msc_pkg::MSC_C_TXGOOD]  = tx_status.valid && tx_en && tx_status.ok
                                    && !tx_status.flow_ctl && tx_status.length >= `MSC_LEN_MIN;
      inc[msc_pkg::MSC_C_UNDER]   = rx_status.valid && rx_en && rx_status.addr_pass && undersize
                                    && rx_status.length >= `MSC_LEN_RUNT && rx_status.crc_ok;
      inc[msc_pkg::MSC_C_FRAG]    = rx_status.valid && rx_en && rx_status.addr_pass && undersize
                                    && rx_status.length >= `MSC_LEN_RUNT && !rx_status.crc_ok;
      inc[msc_pkg::MSC_C_OVER]    = rx_status.valid && rx_en && rx_status.addr_pass && oversize
                                    && rx_status.crc_ok;
      inc[msc_pkg::MSC_C_JAB]     = rx_status.valid && rx_en && rx_status.addr_pass && oversize
                                    && !rx_status.crc_ok;
      nobuf_add = (rx_status.valid && rx_en && !rx_status.flow_ctl && rx_status.desc_empty)
                  ? ((rx_status.dropped_copies == 3'h0) ? 3'h1 : rx_status.dropped_copies)
                  : 3'h0;
      inc[msc_pkg::MSC_C_NOBUF]   = nobuf_add != 3'h0;
      rx_add    = rx_ok ? {48'h0, rx_status.length} : 64'h0;
      tx_add    = inc[msc_pkg::MSC_C_TXGOOD] ? {48'h0, tx_status.length} : 64'h0;
   end

   rx_flow_a: assert property (rx_status.flow_ctl |-> !inc[msc_pkg::MSC_C_RXGOOD])
      else $error("flow control frame counted as good");
   bin_top_a: assert property (oversize |-> !inc[msc_pkg::MSC_C_BIN1024])
      else $error("oversize frame counted in top bin");
   tx_short_a: assert property (tx_status.length < `MSC_LEN_MIN |-> tx_add == 64'h0)
      else $error("short sent frame added octets");

   // Read and write decode
   logic          rd_fire, wr_fire;
   logic [ADDR_W-1:0] rd_off;
   logic [NC-1:0] rd_hit;
   logic          rd_rxl, rd_rxh, rd_txl, rd_txh;

   always_comb
   begin
      rd_off  = {s_axi_araddr[ADDR_W-1:2], 2'b00};
      rd_fire = s_axi_arvalid && s_axi_arready;
      wr_fire = aw_got_r && w_got_r && wr_st_r == msc_pkg::MSC_WR_IDLE;
      rd_hit  = '0;
      rd_hit[msc_pkg::MSC_C_BIN512]  = rd_off == `MSC_OFF_RX_BIN_512_1023;
      rd_hit[msc_pkg::MSC_C_BIN1024] = rd_off == `MSC_OFF_RX_BIN_1024_MAX;
      rd_hit[msc_pkg::MSC_C_RXGOOD]  = rd_off == `MSC_OFF_RX_GOOD_PACKETS;
      rd_hit[msc_pkg::MSC_C_BCAST]   = rd_off == `MSC_OFF_RX_BCAST_PACKETS;
      rd_hit[msc_pkg::MSC_C_MCAST]   = rd_off == `MSC_OFF_RX_MCAST_PACKETS;
      rd_hit[msc_pkg::MSC_C_TXGOOD]  = rd_off == `MSC_OFF_TX_GOOD_PACKETS;
      rd_hit[msc_pkg::MSC_C_NOBUF]   = rd_off == `MSC_OFF_RX_NO_BUFFER;
      rd_hit[msc_pkg::MSC_C_UNDER]   = rd_off == `MSC_OFF_RX_UNDERSIZE;
      rd_hit[msc_pkg::MSC_C_FRAG]    = rd_off == `MSC_OFF_RX_FRAGMENT;
      rd_hit[msc_pkg::MSC_C_OVER]    = rd_off == `MSC_OFF_RX_OVERSIZE;
      rd_hit[msc_pkg::MSC_C_JAB]     = rd_off == `MSC_OFF_RX_JABBER;
      rd_rxl  = rd_off == `MSC_OFF_RX_OCTETS_LOW;
      rd_rxh  = rd_off == `MSC_OFF_RX_OCTETS_HIGH;
      rd_txl  = rd_off == `MSC_OFF_TX_OCTETS_LOW;
      rd_txh  = rd_off == `MSC_OFF_TX_OCTETS_HIGH;
   end

   // Saturating add for octet counters
   function automatic logic [63:0] msc_sat_add(input logic [63:0] a, input logic [63:0] b);
      logic [64:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[64] ? 64'hFFFF_FFFF_FFFF_FFFF : s[63:0];
   endfunction

   // Counter next values
   always_comb
   begin
      for (int i = 0; i < NC; i++)
      begin
         cnt_nxt[i] = (rd_fire && rd_hit[i]) ? `MSC_CNT_RESET : cnt_r[i];
         if (i == int'(msc_pkg::MSC_C_NOBUF))
            cnt_nxt[i] = cnt_nxt[i] + {29'h0, nobuf_add};
         else if (inc[i])
            cnt_nxt[i] = cnt_nxt[i] + 32'h1;
      end
      rxo_hi_snap_nxt = (rd_fire && rd_rxl) ? rxo_r[63:32] : rxo_hi_snap_r;
      txo_hi_snap_nxt = (rd_fire && rd_txl) ? txo_r[63:32] : txo_hi_snap_r;
      rxo_nxt = rxo_r;
      txo_nxt = txo_r;
      if (rd_fire && rd_rxl)
         rxo_nxt = 64'h0;
      if (rd_fire && rd_txl)
         txo_nxt = 64'h0;
      rxo_nxt = msc_sat_add(rxo_nxt, rx_add);
      txo_nxt = msc_sat_add(txo_nxt, tx_add);
   end

   read_clear_a: assert property (ce && rd_fire && rd_hit[msc_pkg::MSC_C_RXGOOD]
      |=> cnt_r[msc_pkg::MSC_C_RXGOOD] <= 32'h1) else $error("read did not clear counter");
   keep_inc_a: assert property (ce && rd_fire && rd_hit[msc_pkg::MSC_C_RXGOOD] && rx_ok
      |=> cnt_r[msc_pkg::MSC_C_RXGOOD] == 32'h1) else $error("increment lost during read");
   rx_snap_a: assert property (ce && rd_fire && rd_rxl
      |=> rxo_hi_snap_r == $past(rxo_r[63:32])) else $error("high word not latched");
   clash_c: cover property (rd_fire && rd_hit[msc_pkg::MSC_C_RXGOOD] && rx_ok);
   nobuf_c: cover property (nobuf_add > 3'h1);
   long_c: cover property (ctl_r[`MSC_CTL_LONG_EN_BIT] && inc[msc_pkg::MSC_C_OVER]);

   // Read channel
   always_comb
   begin
      rd_st_nxt = rd_st_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      case (rd_st_r)
         msc_pkg::MSC_RD_IDLE:
         begin
            if (rd_fire)
            begin
               rd_st_nxt = msc_pkg::MSC_RD_RESP;
               rresp_nxt = `MSC_RESP_OKAY;
               rdata_nxt = 32'h0;
               for (int i = 0; i < NC; i++)
               begin
                  if (rd_hit[i])
                     rdata_nxt = cnt_r[i];
               end
               if (rd_rxl)
                  rdata_nxt = rxo_r[31:0];
               else if (rd_rxh)
                  rdata_nxt = rxo_hi_snap_r;
               else if (rd_txl)
                  rdata_nxt = txo_r[31:0];
               else if (rd_txh)
                  rdata_nxt = txo_hi_snap_r;
               else if (rd_off == `MSC_OFF_CONTROL)
                  rdata_nxt = ctl_r;
               else if (rd_off == `MSC_OFF_MAX_LONG_LEN)
                  rdata_nxt = {16'h0, max_long_r};
               else if (rd_hit == '0)
                  rresp_nxt = `MSC_RESP_SLVERR;
            end
         end
         msc_pkg::MSC_RD_RESP:
         begin
            if (s_axi_rready)
               rd_st_nxt = msc_pkg::MSC_RD_IDLE;
         end
         default:
            rd_st_nxt = msc_pkg::MSC_RD_IDLE;
      endcase
   end

   // Write channel
   always_comb
   begin
      wr_st_nxt    = wr_st_r;
      aw_got_nxt   = aw_got_r;
      w_got_nxt    = w_got_r;
      aw_addr_nxt  = aw_addr_r;
      w_data_nxt   = w_data_r;
      w_strb_nxt   = w_strb_r;
      bresp_nxt    = bresp_r;
      ctl_nxt      = ctl_r;
      max_long_nxt = max_long_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_got_nxt  = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_got_nxt  = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      case (wr_st_r)
         msc_pkg::MSC_WR_IDLE:
         begin
            if (wr_fire)
            begin
               wr_st_nxt  = msc_pkg::MSC_WR_RESP;
               aw_got_nxt = 1'b0;
               w_got_nxt  = 1'b0;
               bresp_nxt  = `MSC_RESP_OKAY;
               if ({aw_addr_r[ADDR_W-1:2], 2'b00} == `MSC_OFF_CONTROL)
               begin
                  for (int b = 0; b < 4; b++)
                  begin
                     if (w_strb_r[b])
                        ctl_nxt[b*8 +: 8] = w_data_r[b*8 +: 8];
                  end
               end
               else if ({aw_addr_r[ADDR_W-1:2], 2'b00} == `MSC_OFF_MAX_LONG_LEN)
               begin
                  for (int b = 0; b < 2; b++)
                  begin
                     if (w_strb_r[b])
                        max_long_nxt[b*8 +: 8] = w_data_r[b*8 +: 8];
                  end
               end
               else
                  bresp_nxt = `MSC_RESP_SLVERR;
            end
         end
         msc_pkg::MSC_WR_RESP:
         begin
            if (s_axi_bready)
               wr_st_nxt = msc_pkg::MSC_WR_IDLE;
         end
         default:
            wr_st_nxt = msc_pkg::MSC_WR_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NC; i++)
            cnt_r[i] <= `MSC_CNT_RESET;
         rxo_r         <= 64'h0;
         txo_r         <= 64'h0;
         rxo_hi_snap_r <= `MSC_CNT_RESET;
         txo_hi_snap_r <= `MSC_CNT_RESET;
         ctl_r         <= `MSC_CTL_RESET;
         max_long_r    <= `MSC_MAX_LONG_RESET;
         rd_st_r       <= msc_pkg::MSC_RD_IDLE;
         wr_st_r       <= msc_pkg::MSC_WR_IDLE;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         aw_addr_r     <= '0;
         w_data_r      <= 32'h0;
         w_strb_r      <= 4'h0;
         rdata_r       <= 32'h0;
         rresp_r       <= `MSC_RESP_OKAY;
         bresp_r       <= `MSC_RESP_OKAY;
      end
      else if (ce)
      begin
         cnt_r         <= cnt_nxt;
         rxo_r         <= rxo_nxt;
         txo_r         <= txo_nxt;
         rxo_hi_snap_r <= rxo_hi_snap_nxt;
         txo_hi_snap_r <= txo_hi_snap_nxt;
         ctl_r         <= ctl_nxt;
         max_long_r    <= max_long_nxt;
         rd_st_r       <= rd_st_nxt;
         wr_st_r       <= wr_st_nxt;
         aw_got_r      <= aw_got_nxt;
         w_got_r       <= w_got_nxt;
         aw_addr_r     <= aw_addr_nxt;
         w_data_r      <= w_data_nxt;
         w_strb_r      <= w_strb_nxt;
         rdata_r       <= rdata_nxt;
         rresp_r       <= rresp_nxt;
         bresp_r       <= bresp_nxt;
      end
   end

   // Outputs from flip-flops
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
      end
      else if (ce)
      begin
         s_axi_arready <= rd_st_nxt == msc_pkg::MSC_RD_IDLE && !rd_fire;
         s_axi_awready <= !aw_got_nxt;
         s_axi_wready  <= !w_got_nxt;
         s_axi_rvalid  <= rd_st_nxt == msc_pkg::MSC_RD_RESP;
         s_axi_bvalid  <= wr_st_nxt == msc_pkg::MSC_WR_RESP;
      end
   end

   always_comb
   begin
      s_axi_rdata  = rdata_r;
      s_axi_rresp  = rresp_r;
      s_axi_bresp  = bresp_r;
   end
endmodule

// ==== tb_mac_rx_tx_statistics_counters.sv ====
// Self-checking bench for the statistics bank
`timescale 1ns/1ps
`include "msc_params.svh"
module tb_mac_rx_tx_statistics_counters;
   logic                    clk           = 1'b0;
   logic                    rst           = 1'b1;
   logic                    ce            = 1'b1;
   msc_pkg::msc_rx_status_t rx_status     = '0;
   msc_pkg::msc_tx_status_t tx_status     = '0;
   logic [15:0]             s_axi_awaddr  = 16'h0000;
   logic                    s_axi_awvalid = 1'b0;
   logic                    s_axi_awready;
   logic [31:0]             s_axi_wdata   = 32'h0000_0000;
   logic [3:0]              s_axi_wstrb   = 4'hF;
   logic                    s_axi_wvalid  = 1'b0;
   logic                    s_axi_wready;
   logic [1:0]              s_axi_bresp;
   logic                    s_axi_bvalid;
   logic                    s_axi_bready  = 1'b0;
   logic [15:0]             s_axi_araddr  = 16'h0000;
   logic                    s_axi_arvalid = 1'b0;
   logic                    s_axi_arready;
   logic [31:0]             s_axi_rdata;
   logic [1:0]              s_axi_rresp;
   logic                    s_axi_rvalid;
   logic                    s_axi_rready  = 1'b0;
   int                      error_cnt     = 0;
   int                      num_checks    = 0;
   logic [31:0]             rd_d;
   logic [1:0]              rd_r;
   logic [31:0]             acc;
   logic [15:0]             cnt_off [15]  = '{`MSC_OFF_RX_BIN_512_1023, `MSC_OFF_RX_BIN_1024_MAX,
      `MSC_OFF_RX_GOOD_PACKETS, `MSC_OFF_RX_BCAST_PACKETS, `MSC_OFF_RX_MCAST_PACKETS,
      `MSC_OFF_TX_GOOD_PACKETS, `MSC_OFF_RX_NO_BUFFER, `MSC_OFF_RX_UNDERSIZE,
      `MSC_OFF_RX_FRAGMENT, `MSC_OFF_RX_OVERSIZE, `MSC_OFF_RX_JABBER, `MSC_OFF_RX_OCTETS_LOW,
      `MSC_OFF_RX_OCTETS_HIGH, `MSC_OFF_TX_OCTETS_LOW, `MSC_OFF_TX_OCTETS_HIGH};
   logic [31:0]             cnt_exp [11]  = '{32'h1, 32'h2, 32'h7, 32'h1, 32'h1, 32'h1, 32'h3,
      32'h1, 32'h1, 32'h1, 32'h1};

   always #5 clk = ~clk;

   msc_stats #(.ADDR_W(16)) u_dut (
      .clk(clk), .rst(rst), .ce(ce), .rx_status(rx_status), .tx_status(tx_status),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
      logic fa;
      logic fw;
      logic fb;
      int   n;
      fb = 1'b0;
      n = 0;
      r = 2'h0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!fb && n < 200)
      begin
         @(negedge clk);
         fa = s_axi_awvalid && s_axi_awready;
         fw = s_axi_wvalid && s_axi_wready;
         fb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
         if (fa)
            s_axi_awvalid <= 1'b0;
         if (fw)
            s_axi_wvalid <= 1'b0;
         if (fb)
            s_axi_bready <= 1'b0;
         n++;
      end
      if (!fb)
         chk(32'h0, 32'h1);
   endtask

   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      logic fa;
      logic fr;
      int   n;
      fr = 1'b0;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!fr && n < 200)
      begin
         @(negedge clk);
         fa = s_axi_arvalid && s_axi_arready;
         fr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (fa)
            s_axi_arvalid <= 1'b0;
         if (fr)
            s_axi_rready <= 1'b0;
         n++;
      end
      if (!fr)
         chk(32'h0, 32'h1);
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
      axi_rd(a, rd_d, rd_r);
      chk(rd_d, e);
   endtask

   // Flags: crc_ok, addr_pass, bcast, mcast, flow_ctl, missed, link_cut, desc_empty
   task automatic rxf(input logic [15:0] len, input logic [7:0] fl, input logic [2:0] dc);
      @(posedge clk);
      rx_status <= {1'b1, len, fl, dc};
      @(posedge clk);
      rx_status <= '0;
   endtask

   task automatic txf(input logic [15:0] len, input logic [1:0] fl);
      @(posedge clk);
      tx_status <= {1'b1, len, fl};
      @(posedge clk);
      tx_status <= '0;
   endtask

   initial
   begin
      #100000;
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (cnt_off[i]) rdchk(cnt_off[i], `MSC_CNT_RESET);
      axi_rd(16'h40BC, rd_d, rd_r);
      chk({30'h0, rd_r}, {30'h0, `MSC_RESP_SLVERR});
      axi_wr(`MSC_OFF_RX_GOOD_PACKETS, 32'h5, rd_r);
      chk({30'h0, rd_r}, {30'h0, `MSC_RESP_SLVERR});
      rxf(16'h0258, 8'hC0, 3'h0);
      axi_wr(`MSC_OFF_CONTROL, 32'h13, rd_r);
      rxf(16'h0258, 8'hC0, 3'h0);
      rxf(16'h0400, 8'hC0, 3'h0);
      rxf(16'h05F2, 8'hC0, 3'h0);
      rxf(16'h0040, 8'hE0, 3'h0);
      rxf(16'h0040, 8'hD0, 3'h0);
      rxf(16'h0258, 8'hC8, 3'h0);
      rxf(16'h0258, 8'hC4, 3'h0);
      rxf(16'h0258, 8'h80, 3'h0);
      rdchk(`MSC_OFF_RX_OCTETS_LOW, 32'h0000_0CCA);
      rdchk(`MSC_OFF_RX_OCTETS_HIGH, 32'h0000_0000);
      txf(16'h0040, 2'b10);
      txf(16'h003F, 2'b10);
      txf(16'h0064, 2'b11);
      txf(16'h0064, 2'b00);
      rdchk(`MSC_OFF_TX_OCTETS_LOW, 32'h0000_0040);
      rdchk(`MSC_OFF_TX_OCTETS_HIGH, 32'h0000_0000);
      rxf(16'h05F3, 8'hC0, 3'h0);
      rxf(16'h05F3, 8'h40, 3'h0);
      rxf(16'h0032, 8'hC0, 3'h0);
      rxf(16'h0032, 8'h40, 3'h0);
      rxf(16'h0014, 8'hC0, 3'h0);
      rxf(16'h0014, 8'h40, 3'h0);
      rxf(16'h0064, 8'h81, 3'h3);
      rxf(16'h0064, 8'hC9, 3'h1);
      rxf(16'h0064, 8'h42, 3'h0);
      axi_wr(`MSC_OFF_CONTROL, 32'h01, rd_r);
      rxf(16'h0040, 8'hE0, 3'h0);
      txf(16'h0040, 2'b10);
      for (int i = 0; i < 11; i++) rdchk(cnt_off[i], cnt_exp[i]);
      for (int i = 0; i < 11; i++) rdchk(cnt_off[i], 32'h0);
      axi_wr(`MSC_OFF_CONTROL, 32'h19, rd_r);
      rxf(16'h05F6, 8'hC0, 3'h0);
      rxf(16'h05F7, 8'hC0, 3'h0);
      rdchk(`MSC_OFF_RX_BIN_1024_MAX, 32'h1);
      rdchk(`MSC_OFF_RX_OVERSIZE, 32'h1);
      axi_wr(`MSC_OFF_CONTROL, 32'h05, rd_r);
      rxf(16'h07D0, 8'hC0, 3'h0);
      rxf(16'h2600, 8'hC0, 3'h0);
      rxf(16'h2601, 8'hC0, 3'h0);
      rdchk(`MSC_OFF_RX_GOOD_PACKETS, 32'h3);
      ce <= 1'b0;
      rxf(16'h0064, 8'hC0, 3'h0);
      ce <= 1'b1;
      rdchk(`MSC_OFF_RX_GOOD_PACKETS, 32'h0);
      rdchk(`MSC_OFF_RX_OVERSIZE, 32'h1);
      acc = 32'h0;
      fork
         repeat (8) rxf(16'h0064, 8'hC0, 3'h0);
         repeat (3)
         begin
            axi_rd(`MSC_OFF_RX_GOOD_PACKETS, rd_d, rd_r);
            acc = acc + rd_d;
         end
      join
      axi_rd(`MSC_OFF_RX_GOOD_PACKETS, rd_d, rd_r);
      chk(acc + rd_d, 32'h8);
      axi_wr(`MSC_OFF_MAX_LONG_LEN, 32'h0000_0800, rd_r);
      chk({30'h0, rd_r}, {30'h0, `MSC_RESP_OKAY});
      rdchk(`MSC_OFF_MAX_LONG_LEN, 32'h0000_0800);
      rdchk(`MSC_OFF_CONTROL, 32'h0000_0005);
      rxf(16'h0801, 8'hC0, 3'h0);
      rdchk(`MSC_OFF_RX_OVERSIZE, 32'h1);
      give_verdict();
   end
endmodule
